// ### core/gpcb_pin_cell.sv
`timescale 1ns/100ps
module gpcb_pin_cell
  import gpcb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       pin_in,
  input  wire logic       pin_edge_select,
  input  wire logic [1:0] pin_driver_mode,
  input  wire logic       pin_read_mode,
  input  wire logic       out_value,
  input  wire logic       out_enable,
  output logic            pin_out,
  output logic            pin_oe,
  output logic            level_read,
  output logic            edge_event
);
  // ----------------------------------------------------------------
  // synchroniser, edge detect, driver
  // ----------------------------------------------------------------
  logic sync1, sync2, sync3;
  logic next_sync1, next_sync2, next_sync3;
  logic next_pin_out, next_pin_oe, next_level_read, next_edge_event;

  always_comb begin
    next_sync1 = pin_in;
    next_sync2 = sync1;
    next_sync3 = sync2;
    if (pin_edge_select == FALLING_EDGE_IRQ) begin
      next_edge_event = sync3 & ~sync2; // [R07]
    end else begin
      next_edge_event = sync2 & ~sync3; // [R06]
    end
    if (pin_read_mode == READ_FORCED_ZERO) begin
      next_level_read = 1'h0; // [R12]
    end else begin
      next_level_read = sync2; // [R11]
    end
    case (pin_driver_mode)
      DRIVE_OFF: begin
        next_pin_out = 1'h0; // [R08]
        next_pin_oe  = 1'h0;
      end
      DRIVE_BOTH_LEVELS: begin
        next_pin_out = out_value; // [R09]
        next_pin_oe  = 1'h1;
      end
      DRIVE_LOW_ONLY: begin
        next_pin_out = 1'h0; // [R10]
        next_pin_oe  = ~out_value;
      end
      THREE_STATE_DRIVE: begin
        next_pin_out = out_value; // [R10]
        next_pin_oe  = out_enable;
      end
      default: begin
        next_pin_out = 1'h0;
        next_pin_oe  = 1'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1      <= 1'h0;
      sync2      <= 1'h0;
      sync3      <= 1'h0;
      pin_out    <= 1'h0;
      pin_oe     <= 1'h0;
      level_read <= 1'h0;
      edge_event <= 1'h0;
    end else begin
      sync1      <= next_sync1;
      sync2      <= next_sync2;
      sync3      <= next_sync3;
      pin_out    <= next_pin_out;
      pin_oe     <= next_pin_oe;
      level_read <= next_level_read;
      edge_event <= next_edge_event;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  rise_edge_a : assert property ( // [R06]
    @(posedge clk) disable iff (!rst_n)
    (pin_edge_select == RISING_EDGE_IRQ) && sync2 && !sync3 |=> edge_event)
    else $error("rising edge missed");
  fall_edge_a : assert property ( // [R07]
    @(posedge clk) disable iff (!rst_n)
    (pin_edge_select == FALLING_EDGE_IRQ) && !sync2 && sync3 |=> edge_event)
    else $error("falling edge missed");
  wrong_edge_a : assert property ( // [R07]
    @(posedge clk) disable iff (!rst_n)
    (pin_edge_select == FALLING_EDGE_IRQ) && sync2 |=> !edge_event)
    else $error("event on wrong edge");
  drive_off_a : assert property ( // [R08]
    @(posedge clk) disable iff (!rst_n)
    pin_driver_mode == DRIVE_OFF |=> !pin_oe)
    else $error("driver on while disabled");
  push_pull_a : assert property ( // [R09]
    @(posedge clk) disable iff (!rst_n)
    pin_driver_mode == DRIVE_BOTH_LEVELS |=> pin_oe && (pin_out == $past(out_value)))
    else $error("push-pull drive wrong");
  open_drain_a : assert property ( // [R10]
    @(posedge clk) disable iff (!rst_n)
    pin_driver_mode == DRIVE_LOW_ONLY |=> !pin_out && (pin_oe == !$past(out_value)))
    else $error("open-drain drive wrong");
  read_zero_a : assert property ( // [R12]
    @(posedge clk) disable iff (!rst_n)
    pin_read_mode == READ_FORCED_ZERO |=> !level_read)
    else $error("forced-zero read shows level");
endmodule : gpcb_pin_cell

// ### core/gpcb_pkg.sv
package gpcb_pkg;
  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  OFS_PIN_LEVEL  = 8'h00;
  localparam logic [7:0]  OFS_OUT_VALUE  = 8'h04;
  localparam logic [7:0]  OFS_OUT_ENABLE = 8'h08;
  localparam logic [7:0]  OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_MASK   = 8'h10;
  localparam logic [7:0]  OFS_CFG_LO     = 8'h40;
  localparam logic [7:0]  OFS_CFG_HI     = 8'h44;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  // ----------------------------------------------------------------
  // per-pin field layout
  // ----------------------------------------------------------------
  localparam int unsigned PIN_COUNT      = 16;
  localparam int unsigned PINS_PER_WORD  = 8;
  localparam int unsigned SLICE_W        = 4;
  localparam int unsigned EDGE_POS       = 3;
  localparam int unsigned MODE_POS       = 1;
  localparam int unsigned READ_POS       = 0;
  localparam logic [31:0] RST_CFG        = 32'h0000_0000;
  localparam logic [15:0] RST_PINREG     = 16'h0000;
  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic        RISING_EDGE_IRQ   = 1'h0;
  localparam logic        FALLING_EDGE_IRQ  = 1'h1;
  localparam logic [1:0]  DRIVE_OFF         = 2'h0;
  localparam logic [1:0]  DRIVE_BOTH_LEVELS = 2'h1;
  localparam logic [1:0]  DRIVE_LOW_ONLY    = 2'h2;
  localparam logic [1:0]  THREE_STATE_DRIVE = 2'h3;
  localparam logic        READ_PIN_LEVEL    = 1'h0;
  localparam logic        READ_FORCED_ZERO  = 1'h1;
endpackage : gpcb_pkg

// ### core/gpcb_top.sv
// Contract
// [R01] writes need bank unlocked by key
// [R02] word at 0x40 configures pins 0-7
// [R03] word at 0x44 configures pins 8-15
// [R04] four-bit slice per pin, edge/mode/read
// [R05] top pin: edge 31, mode 30:29, read 28
// [R06] edge select 0: interrupt on rising
// [R07] edge select 1: interrupt on falling
// [R08] driver mode 0: output disabled
// [R09] driver mode 1: drive both levels
// [R10] mode 2 low only, 3 enable-controlled
// [R11] read mode 0 returns pin level
// [R12] read mode 1 returns zero
// [R13] all fields reset to zero, read-write
// [R14] locked writes ignored, reads always allowed
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
module gpcb_top
  import gpcb_pkg::*;
#(
  parameter int unsigned PINS = 16
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       bank_unlock_key,
  input  wire logic [PINS-1:0]            pin_in,
  output logic      [PINS-1:0]            pin_out,
  output logic      [PINS-1:0]            pin_oe,
  output logic                            irq,
  input  wire logic [gpcb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [gpcb_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic      [1:0]                 s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [gpcb_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic      [gpcb_pkg::DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]                 s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);
  import gpcb_pkg::*;

  if (PINS != PIN_COUNT) begin : g_bad_pins
    $error("gpcb_top serves exactly sixteen pins");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

  function automatic logic [31:0] merge(input logic [31:0] old_word,
                                        input logic [31:0] new_word,
                                        input logic [3:0]  strb);
    merge = (old_word & ~lane_mask(strb)) | (new_word & lane_mask(strb));
  endfunction : merge

  function automatic logic [15:0] merge_half(input logic [15:0] old_half,
                                             input logic [15:0] new_half,
                                             input logic [15:0] mask);
    merge_half = (old_half & ~mask) | (new_half & mask);
  endfunction : merge_half

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == OFS_PIN_LEVEL) || (addr == OFS_OUT_VALUE) ||
                (addr == OFS_OUT_ENABLE) || (addr == OFS_IRQ_STATUS) ||
                (addr == OFS_IRQ_MASK) || (addr == OFS_CFG_LO) ||
                (addr == OFS_CFG_HI);
  endfunction : is_mapped

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic             aw_full, next_aw_full;
  logic [7:0]       aw_addr, next_aw_addr;
  logic             w_full, next_w_full;
  logic [31:0]      w_data, next_w_data;
  logic [3:0]       w_strb, next_w_strb;
  logic             bvalid, next_bvalid;
  logic [1:0]       bresp, next_bresp;
  logic             rvalid, next_rvalid;
  logic [31:0]      rdata, next_rdata;
  logic [1:0]       rresp, next_rresp;
  logic [31:0]      cfg_lo, next_cfg_lo;
  logic [31:0]      cfg_hi, next_cfg_hi;
  logic [15:0]      out_value, next_out_value;
  logic [15:0]      out_enable, next_out_enable;
  logic [15:0]      irq_status, next_irq_status;
  logic [15:0]      irq_mask, next_irq_mask;

  logic             aw_hs, w_hs, ar_hs, wr_fire;
  logic [7:0]       wr_addr, rd_addr;
  logic [31:0]      wr_data;
  logic [3:0]       wr_strb;
  logic [31:0]      strb_mask;
  logic [15:0]      status_clear;
  logic [15:0]      level_read;
  logic [15:0]      edge_event;
  logic [63:0]      cfg_all;

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_full && !bvalid;
  assign s_axi_wready  = !w_full && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  assign aw_hs   = s_axi_awvalid && s_axi_awready;
  assign w_hs    = s_axi_wvalid && s_axi_wready;
  assign ar_hs   = s_axi_arvalid && s_axi_arready;
  assign wr_addr = aw_full ? aw_addr : {s_axi_awaddr[7:2], 2'h0};
  assign wr_data = w_full ? w_data : s_axi_wdata;
  assign wr_strb = w_full ? w_strb : s_axi_wstrb;
  assign strb_mask = lane_mask(wr_strb);
  assign wr_fire = (aw_full || aw_hs) && (w_full || w_hs);
  assign rd_addr = {s_axi_araddr[7:2], 2'h0};

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    next_aw_full    = aw_full;
    next_aw_addr    = aw_addr;
    next_w_full     = w_full;
    next_w_data     = w_data;
    next_w_strb     = w_strb;
    next_bvalid     = bvalid;
    next_bresp      = bresp;
    next_rvalid     = rvalid;
    next_rdata      = rdata;
    next_rresp      = rresp;
    next_cfg_lo     = cfg_lo;
    next_cfg_hi     = cfg_hi;
    next_out_value  = out_value;
    next_out_enable = out_enable;
    next_irq_mask   = irq_mask;
    status_clear    = 16'h0000;
    if (aw_hs) begin
      next_aw_full = 1'h1;
      next_aw_addr = {s_axi_awaddr[7:2], 2'h0};
    end
    if (w_hs) begin
      next_w_full = 1'h1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'h0;
    end
    if (wr_fire) begin
      next_aw_full = 1'h0;
      next_w_full  = 1'h0;
      next_bvalid  = 1'h1;
      next_bresp   = is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      case (wr_addr)
        OFS_CFG_LO: begin
          if (bank_unlock_key) begin
            next_cfg_lo = merge(cfg_lo, wr_data, wr_strb); // [R01] [R02] [R14]
          end
        end
        OFS_CFG_HI: begin
          if (bank_unlock_key) begin
            next_cfg_hi = merge(cfg_hi, wr_data, wr_strb); // [R01] [R03] [R14]
          end
        end
        OFS_OUT_VALUE: begin
          next_out_value = merge_half(out_value, wr_data[15:0], strb_mask[15:0]);
        end
        OFS_OUT_ENABLE: begin
          next_out_enable = merge_half(out_enable, wr_data[15:0], strb_mask[15:0]);
        end
        OFS_IRQ_MASK: begin
          next_irq_mask = merge_half(irq_mask, wr_data[15:0], strb_mask[15:0]);
        end
        OFS_IRQ_STATUS: begin
          status_clear = wr_data[15:0] & strb_mask[15:0];
        end
        default: begin
          next_bresp = is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
        end
      endcase
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'h0;
    end
    if (ar_hs) begin
      next_rvalid = 1'h1;
      next_rresp  = is_mapped(rd_addr) ? RESP_OKAY : RESP_SLVERR;
      case (rd_addr)
        OFS_PIN_LEVEL:  next_rdata = {16'h0000, level_read}; // [R11] [R12]
        OFS_OUT_VALUE:  next_rdata = {16'h0000, out_value};
        OFS_OUT_ENABLE: next_rdata = {16'h0000, out_enable};
        OFS_IRQ_STATUS: next_rdata = {16'h0000, irq_status};
        OFS_IRQ_MASK:   next_rdata = {16'h0000, irq_mask};
        OFS_CFG_LO:     next_rdata = cfg_lo; // [R13] [R14]
        OFS_CFG_HI:     next_rdata = cfg_hi; // [R13] [R14]
        default:        next_rdata = 32'h0000_0000;
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_irq_status = (irq_status & ~status_clear) | edge_event;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full    <= 1'h0;
      aw_addr    <= 8'h00;
      w_full     <= 1'h0;
      w_data     <= 32'h0000_0000;
      w_strb     <= 4'h0;
      bvalid     <= 1'h0;
      bresp      <= RESP_OKAY;
      rvalid     <= 1'h0;
      rdata      <= 32'h0000_0000;
      rresp      <= RESP_OKAY;
      cfg_lo     <= RST_CFG; // [R13]
      cfg_hi     <= RST_CFG; // [R13]
      out_value  <= RST_PINREG;
      out_enable <= RST_PINREG;
      irq_status <= RST_PINREG;
      irq_mask   <= RST_PINREG;
    end else begin
      aw_full    <= next_aw_full;
      aw_addr    <= next_aw_addr;
      w_full     <= next_w_full;
      w_data     <= next_w_data;
      w_strb     <= next_w_strb;
      bvalid     <= next_bvalid;
      bresp      <= next_bresp;
      rvalid     <= next_rvalid;
      rdata      <= next_rdata;
      rresp      <= next_rresp;
      cfg_lo     <= next_cfg_lo;
      cfg_hi     <= next_cfg_hi;
      out_value  <= next_out_value;
      out_enable <= next_out_enable;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // pin cells
  // ----------------------------------------------------------------
  assign cfg_all = {cfg_hi, cfg_lo};

  for (genvar i = 0; i < PINS; i++) begin : g_pin
    logic [SLICE_W-1:0] slice;
    assign slice = cfg_all[SLICE_W*i +: SLICE_W]; // [R04] [R05]
    gpcb_pin_cell u_cell (
      .clk             (clk),
      .rst_n           (rst_n),
      .pin_in          (pin_in[i]),
      .pin_edge_select (slice[EDGE_POS]), // [R04]
      .pin_driver_mode (slice[MODE_POS +: 2]), // [R04]
      .pin_read_mode   (slice[READ_POS]), // [R04]
      .out_value       (out_value[i]),
      .out_enable      (out_enable[i]),
      .pin_out         (pin_out[i]),
      .pin_oe          (pin_oe[i]),
      .level_read      (level_read[i]),
      .edge_event      (edge_event[i])
    );
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  locked_write_a : assert property ( // [R14]
    @(posedge clk) disable iff (!rst_n)
    wr_fire && !bank_unlock_key &&
    ((wr_addr == OFS_CFG_LO) || (wr_addr == OFS_CFG_HI))
    |=> $stable(cfg_lo) && $stable(cfg_hi) && bvalid && (bresp == RESP_OKAY))
    else $error("locked write changed configuration");
  lo_write_a : assert property ( // [R02]
    @(posedge clk) disable iff (!rst_n)
    wr_fire && bank_unlock_key && (wr_addr == OFS_CFG_LO) && (wr_strb == 4'hf)
    |=> (cfg_lo == $past(wr_data)) && $stable(cfg_hi))
    else $error("low word write lost");
  hi_write_a : assert property ( // [R03]
    @(posedge clk) disable iff (!rst_n)
    wr_fire && bank_unlock_key && (wr_addr == OFS_CFG_HI) && (wr_strb == 4'hf)
    |=> (cfg_hi == $past(wr_data)) && $stable(cfg_lo))
    else $error("high word write lost");
  cfg_reset_a : assert property ( // [R13]
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> (cfg_lo == RST_CFG) && (cfg_hi == RST_CFG))
    else $error("configuration not cleared by reset");
  cfg_readback_a : assert property ( // [R13]
    @(posedge clk) disable iff (!rst_n)
    ar_hs && (rd_addr == OFS_CFG_HI) |=> rvalid && (rdata == $past(cfg_hi)))
    else $error("high word readback wrong");
  sticky_set_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    |edge_event |=> ((irq_status & $past(edge_event)) == $past(edge_event)))
    else $error("event lost against clear");
  unmapped_write_a : assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_fire && !is_mapped(wr_addr) |=> bvalid && (bresp == RESP_SLVERR))
    else $error("unmapped write not refused");
endmodule : gpcb_top

// ### tb/tb_gpcb_top.sv
`timescale 1ns/100ps
module tb_gpcb_top;
  import gpcb_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk;
  logic        rst_n;
  logic        bank_unlock_key;
  logic [15:0] pin_in;
  logic [15:0] pin_out;
  logic [15:0] pin_oe;
  logic        irq;
  logic [7:0]  s_axi_awaddr;
  logic [7:0]  s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [31:0] s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [1:0]  s_axi_bresp;
  logic [1:0]  s_axi_rresp;
  int          n_mismatch;
  int          tests_run;
  logic [31:0] seed;
  logic [31:0] rd;
  logic [31:0] cfg_lo;
  logic [31:0] cfg_hi;
  logic [31:0] ov;
  logic [31:0] oe;
  logic [31:0] mk;
  logic [15:0] pa;
  logic [15:0] pb;
  logic [15:0] ev;
  logic [1:0]  rsp;

  gpcb_top #(.PINS(16)) i_gpcb_top (
    .clk(clk), .rst_n(rst_n), .bank_unlock_key(bank_unlock_key),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [15:0] rnd16();
    logic [31:0] r;
    r = rnd();
    return r[15:0];
  endfunction : rnd16

  // gathers bit pos of every four-bit pin slice
  function automatic logic [15:0] sel_bits(input logic [63:0] cfg, input int pos);
    logic [15:0] s;
    for (int i = 0; i < 16; i++) s[i] = cfg[4*i+pos];
    return s;
  endfunction : sel_bits

  // returns {enable, value} for all pins from the driver mode fields
  function automatic logic [31:0] drv_exp(input logic [63:0] cfg, input logic [15:0] v,
                                          input logic [15:0] e);
    logic [15:0] o;
    logic [15:0] en;
    for (int i = 0; i < 16; i++) begin
      case (cfg[4*i+1 +: 2])
        2'h0: {en[i], o[i]} = 2'h0;
        2'h1: {en[i], o[i]} = {1'b1, v[i]};
        2'h2: {en[i], o[i]} = {~v[i], 1'b0};
        default: {en[i], o[i]} = {e[i], v[i]};
      endcase
    end
    return {en, o};
  endfunction : drv_exp

  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_val

  task automatic chk_resp(input string nm, input logic [1:0] exp, input logic [1:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_resp

  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hfcab;
    n_mismatch = 0;
    tests_run = 0;
    rst_n = 1'b0;
    bank_unlock_key = 1'b0;
    pin_in = 16'h0000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(OFS_CFG_LO, rd, rsp);
    chk_val("cfg_lo reset", 32'h0, rd);
    axi_rd(OFS_CFG_HI, rd, rsp);
    chk_val("cfg_hi reset", 32'h0, rd);
    $display("test reset done");
    axi_wr(OFS_CFG_LO, rnd(), rsp);
    chk_resp("locked write resp", RESP_OKAY, rsp);
    axi_rd(OFS_CFG_LO, rd, rsp);
    chk_val("cfg_lo locked", 32'h0, rd);
    $display("test locked done");
    bank_unlock_key <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      cfg_lo = (i < 4) ? 32'h2222_2222 * i : rnd();
      cfg_hi = (i < 4) ? 32'h2222_2222 * (3 - i) : rnd();
      ov = rnd();
      oe = rnd();
      axi_wr(OFS_CFG_LO, cfg_lo, rsp);
      axi_wr(OFS_CFG_HI, cfg_hi, rsp);
      axi_wr(OFS_OUT_VALUE, ov, rsp);
      axi_wr(OFS_OUT_ENABLE, oe, rsp);
      axi_rd(OFS_CFG_LO, rd, rsp);
      chk_val("cfg_lo", cfg_lo, rd);
      axi_rd(OFS_CFG_HI, rd, rsp);
      chk_val("cfg_hi", cfg_hi, rd);
      repeat (2) @(posedge clk);
      rd = drv_exp({cfg_hi, cfg_lo}, ov[15:0], oe[15:0]);
      chk_val("pins", rd, {pin_oe, pin_out});
      pin_in <= rnd16();
      repeat (8) @(posedge clk);
      axi_rd(OFS_PIN_LEVEL, rd, rsp);
      ev = pin_in & ~sel_bits({cfg_hi, cfg_lo}, 0);
      chk_val("pin level", {16'h0, ev}, rd);
    end
    $display("test config done");
    for (int i = 0; i < 6; i++) begin
      cfg_lo = rnd();
      cfg_hi = rnd();
      axi_wr(OFS_CFG_LO, cfg_lo, rsp);
      axi_wr(OFS_CFG_HI, cfg_hi, rsp);
      axi_wr(OFS_IRQ_MASK, 32'h0000_ffff, rsp);
      pa = rnd16();
      pin_in <= pa;
      repeat (8) @(posedge clk);
      axi_wr(OFS_IRQ_STATUS, 32'h0000_ffff, rsp);
      axi_rd(OFS_IRQ_STATUS, rd, rsp);
      chk_val("status cleared", 32'h0, rd);
      pb = rnd16();
      pin_in <= pb;
      repeat (8) @(posedge clk);
      ev = sel_bits({cfg_hi, cfg_lo}, 3);
      ev = (~ev & ~pa & pb) | (ev & pa & ~pb);
      axi_rd(OFS_IRQ_STATUS, rd, rsp);
      chk_val("status", {16'h0, ev}, rd);
      chk_val("irq all", {31'h0, |ev}, {31'h0, irq});
      mk = rnd();
      axi_wr(OFS_IRQ_MASK, mk, rsp);
      @(posedge clk);
      chk_val("irq masked", {31'h0, |(ev & mk[15:0])}, {31'h0, irq});
      axi_wr(OFS_IRQ_STATUS, {16'h0, ev}, rsp);
      @(posedge clk);
      chk_val("irq clear", 32'h0, {31'h0, irq});
    end
    $display("test edge done");
    axi_wr(8'h20, rnd(), rsp);
    chk_resp("unmapped write", RESP_SLVERR, rsp);
    axi_rd(8'h20, rd, rsp);
    chk_resp("unmapped read", RESP_SLVERR, rsp);
    chk_val("unmapped data", 32'h0, rd);
    s_axi_wstrb <= 4'h3;
    axi_wr(OFS_CFG_LO, ~cfg_lo, rsp);
    s_axi_wstrb <= 4'hf;
    axi_rd(OFS_CFG_LO, rd, rsp);
    chk_val("cfg_lo strobe", {cfg_lo[31:16], ~cfg_lo[15:0]}, rd);
    bank_unlock_key <= 1'b0;
    axi_wr(OFS_CFG_HI, ~cfg_hi, rsp);
    axi_rd(OFS_CFG_HI, rd, rsp);
    chk_val("cfg_hi relocked", cfg_hi, rd);
    $display("test map done");
    stop_test();
  end
endmodule : tb_gpcb_top
